// *** shared/epc_pkg.sv ***
package epc_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_DIV_HI  = 8'hEE;
    localparam logic [7:0] IDX_DIV_LO  = 8'hEF;
    localparam logic [7:0] IDX_CONFIG  = 8'hF0;
    localparam logic [7:0] IDX_PROTECT = 8'hF1;
    localparam logic [7:0] IDX_TEST    = 8'hF2;
    localparam logic [7:0] IDX_PROG    = 8'hF3;
    localparam logic [7:0] IDX_STATUS  = 8'hF4;

    // reset values
    localparam logic [7:0] RST_PROTECT = 8'hFF;
    localparam logic [7:0] RST_PROG    = 8'h80;
    localparam logic [3:0] RST_CFG_LO  = 4'hC;

    // program_erase_control fields
    localparam int PRG_BULK_ERASE_PROTECT = 7;
    localparam int PRG_AUTO  = 5;
    localparam int PRG_BYTE  = 4;
    localparam int PRG_ROW   = 3;
    localparam int PRG_ERASE = 2;
    localparam int PRG_LATCH = 1;
    localparam int PRG_HV    = 0;

    // module_configuration fields
    localparam int CFG_NODBG = 7;
    localparam int CFG_SHADOW_HIDE = 6;
    localparam int CFG_WAIT  = 2;
    localparam int CFG_PLOCK = 1;
    localparam int CFG_SPARE = 0;

    // block_protection fields
    localparam int PROT_SHADOW = 7;

    // status fields
    localparam int STS_ABORT = 0;
    localparam int STS_DONE  = 1;

    // array offsets within the 2 KiB window, one range per protect bit
    localparam logic [10:0] SHADOW_ADDR = 11'h7C0;
    localparam logic [10:0] BLK_LO [6] = '{11'h7C0, 11'h780, 11'h700,
                                           11'h600, 11'h400, 11'h000};
    localparam logic [10:0] BLK_HI [6] = '{11'h7FF, 11'h7BF, 11'h77F,
                                           11'h6FF, 11'h5FF, 11'h3FF};

    // timing: self-time pulse and program/erase cycle
    localparam int TICK_NS      = 35000;
    localparam int PROG_US      = 10000;
    localparam int PROG_TICKS   = (PROG_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam logic [8:0] PROG_TICKS_W = 9'(PROG_TICKS);
endpackage

// *** rtl/epc_top.sv ***
`timescale 1ns/100ps
// Function
// - divider loads from shadow, reads always, writes only unlatched, once in normal mode
// - oscillator divided by divider value yields the 35 us self-time tick
// - zero divider blocks program/erase start and refuses latch enable writes
// - config upper nibble from shadow; bit3 one, wait stop one, others zero
// - debug lockout active when disable bit is 0; bit writable in special mode
// - shadow word replaces array bytes 0FC0/0FC1 while shadow hide is 0
// - shadow high nibble to config, high bits 1:0 and low byte to divider
// - wait_clock_stop set stops module clock during wait mode
// - protect lock freezes block and bulk protection; write-once in normal mode
// - block protection resets all ones, writable only with hv and lock clear
// - shadow protect blocks program and erase of the shadow word
// - six protect bits cover 1024,512,256,128,64,64 byte ranges from 0800
// - normal mode ignores test register writes and reads it as zero
// - bulk erase protect refuses bulk and row erase; writable without hv/lock
// - self terminate clears hv_apply when the timed cycle completes
// - erase size: 00 bulk, 01 row of 32 bytes, 1x byte or word
// - single erase hits only the latched byte or aligned word
// - latch enable lets array writes be captured; frozen while hv_apply set
// - hv_apply sets only when latch_enable already set
// - while hv_apply set controls, latches frozen and array writes ignored
// - stop or clock-stopping wait aborts program/erase, marked unsuccessful
module epc_top #(
    parameter int ADR_W = 10
) (
    // system
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    output logic                  ack_o,
    // pins
    input  wire logic             special_mode_low_i,
    input  wire logic             oscillator_input_i,
    // chip state, same clock
    input  wire logic             wait_mode_i,
    input  wire logic             stop_mode_i,
    input  wire logic [15:0]      shadow_word_i,
    // array write path, same clock
    input  wire logic             arr_wr_i,
    input  wire logic [10:0]      arr_addr_i,
    input  wire logic [15:0]      arr_data_i,
    input  wire logic             arr_word_i,
    // program/erase engine
    output logic                  hv_o,
    output logic                  latch_o,
    output logic                  erase_o,
    output logic [1:0]            erase_size_o,
    output logic [10:0]           lat_addr_o,
    output logic [15:0]           lat_data_o,
    output logic                  lat_word_o,
    output logic                  shadow_sel_o,
    output logic                  debug_lockout_o,
    output logic                  clock_stop_o,
    output logic                  array_wr_block_o
);

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [1:0] smod_sync_q;
    logic [2:0] osc_sync_q;
    logic       special_q;

    // pins pass two flops; osc third flop only feeds edge detection
    always_ff @(posedge clk_i) begin
        smod_sync_q <= {smod_sync_q[0], special_mode_low_i};
        osc_sync_q  <= {osc_sync_q[1:0], oscillator_input_i};
    end

    wire osc_rise = osc_sync_q[1] & ~osc_sync_q[2];
    assign special_q = ~smod_sync_q[1];

    // ***************************************************************
    // bus decode
    // ***************************************************************
    logic       ack_q;
    logic       load_q;
    logic [7:0] div_hi_q;
    logic [7:0] div_lo_q;
    logic [7:0] cfg_q;
    logic [7:0] prot_q;
    logic [7:0] test_q;
    logic [7:0] prog_q;
    logic [1:0] sts_q;
    logic       lock_hi_q;
    logic       lock_lo_q;
    logic       plock_done_q;

    wire [7:0] idx   = adr_i[9:2];
    wire       req   = cyc_i & stb_i & ~ack_q & ~load_q;
    wire       wr    = req & we_i & sel_i[0];
    wire [7:0] wd    = dat_i[7:0];
    wire       hv    = prog_q[epc_pkg::PRG_HV];
    wire       latch = prog_q[epc_pkg::PRG_LATCH];
    wire [9:0] div   = {div_hi_q[1:0], div_lo_q};
    wire       div_z = (div == 10'h000);
    wire       plock = cfg_q[epc_pkg::CFG_PLOCK];

    wire wr_dh  = wr & (idx == epc_pkg::IDX_DIV_HI);
    wire wr_dl  = wr & (idx == epc_pkg::IDX_DIV_LO);
    wire wr_cfg = wr & (idx == epc_pkg::IDX_CONFIG);
    wire wr_prt = wr & (idx == epc_pkg::IDX_PROTECT);
    wire wr_tst = wr & (idx == epc_pkg::IDX_TEST);
    wire wr_prg = wr & (idx == epc_pkg::IDX_PROG);
    wire wr_sts = wr & (idx == epc_pkg::IDX_STATUS);

    // read mux; unmapped indices answer zero
    wire [7:0] rd =
        (idx == epc_pkg::IDX_DIV_HI)  ? div_hi_q :
        (idx == epc_pkg::IDX_DIV_LO)  ? div_lo_q :
        (idx == epc_pkg::IDX_CONFIG)  ? cfg_q :
        (idx == epc_pkg::IDX_PROTECT) ? prot_q :
        (idx == epc_pkg::IDX_TEST)    ? (special_q ? test_q : 8'h00) :
        (idx == epc_pkg::IDX_PROG)    ? prog_q :
        (idx == epc_pkg::IDX_STATUS)  ? {6'h00, sts_q} : 8'h00;

    // one wait state: ack in the cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_o <= req ? {24'h00_0000, rd} : 32'h0000_0000;
        end
    end

    // ***************************************************************
    // divider and configuration
    // ***************************************************************
    // reset takes constants; the shadow word is copied one cycle after
    // release, and the bus is held off until then
    wire div_ok_hi = wr_dh & ~latch & (special_q | ~lock_hi_q);
    wire div_ok_lo = wr_dl & ~latch & (special_q | ~lock_lo_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_q    <= 1'b1;
            div_hi_q  <= 8'h00;
            div_lo_q  <= 8'h00;
            lock_hi_q <= 1'b0;
            lock_lo_q <= 1'b0;
        end else if (load_q) begin
            load_q   <= 1'b0;
            div_hi_q <= {6'h00, shadow_word_i[9:8]};
            div_lo_q <= shadow_word_i[7:0];
        end else begin
            if (div_ok_hi) begin
                div_hi_q  <= {6'h00, wd[1:0]};
                lock_hi_q <= 1'b1;
            end
            if (div_ok_lo) begin
                div_lo_q  <= wd;
                lock_lo_q <= 1'b1;
            end
        end
    end

    // debug and shadow-hide bits load from shadow, and take bus writes only in special mode
    wire plock_ok = special_q | ~plock_done_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q        <= {4'h0, epc_pkg::RST_CFG_LO};
            plock_done_q <= 1'b0;
        end else if (load_q) begin
            cfg_q[7:4] <= shadow_word_i[15:12];
        end else if (wr_cfg) begin
            if (special_q) begin
                cfg_q[epc_pkg::CFG_NODBG] <= wd[epc_pkg::CFG_NODBG];
                cfg_q[epc_pkg::CFG_SHADOW_HIDE] <= wd[epc_pkg::CFG_SHADOW_HIDE];
            end
            cfg_q[epc_pkg::CFG_WAIT]  <= wd[epc_pkg::CFG_WAIT];
            cfg_q[epc_pkg::CFG_SPARE] <= wd[epc_pkg::CFG_SPARE];
            if (plock_ok) begin
                cfg_q[epc_pkg::CFG_PLOCK] <= wd[epc_pkg::CFG_PLOCK];
                plock_done_q              <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // protection and test registers
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= epc_pkg::RST_PROTECT;
            test_q <= 8'h00;
        end else begin
            if (wr_prt & ~hv & ~plock) begin
                prot_q <= {wd[7], 1'b1, wd[5:0]};
            end
            if (wr_tst & special_q) begin
                test_q <= wd;
            end
        end
    end

    // ***************************************************************
    // self-time clock and cycle timer
    // ***************************************************************
    logic [9:0] tdiv_q;
    logic [8:0] ticks_q;
    logic       tick_q;

    // a tick every div oscillator edges; a zero divider never ticks
    wire tick_end = osc_rise & ~div_z & (tdiv_q >= div - 10'd1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdiv_q <= 10'h000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_end;
            if (tick_end) begin
                tdiv_q <= 10'h000;
            end else if (osc_rise) begin
                tdiv_q <= tdiv_q + 10'd1;
            end
        end
    end

    wire cyc_done = hv & (ticks_q >= epc_pkg::PROG_TICKS_W);

    // counting restarts whenever hv_apply is low
    always_ff @(posedge clk_i) begin
        if (rst_i | ~hv) begin
            ticks_q <= 9'h000;
        end else if (tick_q & ~cyc_done) begin
            ticks_q <= ticks_q + 9'd1;
        end
    end

    // ***************************************************************
    // target protection check
    // ***************************************************************
    logic [5:0] blk_hit;
    logic [10:0] lat_addr_q;
    logic        captured_q;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_blk
            assign blk_hit[g] = (lat_addr_q >= epc_pkg::BLK_LO[g]) &
                                (lat_addr_q <= epc_pkg::BLK_HI[g]);
        end
    endgenerate

    wire shadow_tgt = ~cfg_q[epc_pkg::CFG_SHADOW_HIDE] &
                      (lat_addr_q[10:1] == epc_pkg::SHADOW_ADDR[10:1]);
    wire erase_m = prog_q[epc_pkg::PRG_ERASE];
    wire bulk_m  = erase_m & ~prog_q[epc_pkg::PRG_BYTE] &
                   ~prog_q[epc_pkg::PRG_ROW];
    wire row_m   = erase_m & ~prog_q[epc_pkg::PRG_BYTE] &
                   prog_q[epc_pkg::PRG_ROW];
    wire blocked =
        (shadow_tgt ? prot_q[epc_pkg::PROT_SHADOW]
                    : |(blk_hit & prot_q[5:0])) |
        ((bulk_m | row_m) & prog_q[epc_pkg::PRG_BULK_ERASE_PROTECT]) |
        (bulk_m & |prot_q[5:0]);
    wire abort = hv & (stop_mode_i | (wait_mode_i & cfg_q[epc_pkg::CFG_WAIT]));

    // ***************************************************************
    // program/erase control
    // ***************************************************************
    wire hv_start = wr_prg & ~hv & latch & wd[epc_pkg::PRG_HV] & ~div_z &
                    captured_q & ~blocked;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_q <= epc_pkg::RST_PROG;
        end else if (hv) begin
            // controls frozen; only hv itself may drop
            if (abort | (cyc_done & prog_q[epc_pkg::PRG_AUTO]) |
                (wr_prg & ~wd[epc_pkg::PRG_HV])) begin
                prog_q[epc_pkg::PRG_HV] <= 1'b0;
            end
        end else if (wr_prg) begin
            if (~plock) begin
                prog_q[epc_pkg::PRG_BULK_ERASE_PROTECT] <= wd[epc_pkg::PRG_BULK_ERASE_PROTECT];
            end
            prog_q[5:2] <= wd[5:2];
            if (~div_z) begin
                prog_q[epc_pkg::PRG_LATCH] <= wd[epc_pkg::PRG_LATCH];
            end
            prog_q[epc_pkg::PRG_HV] <= hv_start;
        end
    end

    // latches fill only while latched and not under high voltage;
    // a misaligned word keeps just its low byte
    logic [15:0] lat_data_q;
    logic        lat_word_q;

    always_ff @(posedge clk_i) begin
        if (rst_i | ~latch) begin
            lat_addr_q <= 11'h000;
            lat_data_q <= 16'h0000;
            lat_word_q <= 1'b0;
            captured_q <= 1'b0;
        end else if (arr_wr_i & ~hv) begin
            lat_addr_q <= arr_addr_i;
            lat_data_q <= arr_data_i;
            lat_word_q <= arr_word_i & ~arr_addr_i[0];
            captured_q <= 1'b1;
        end
    end

    // status: abort and done are sticky, cleared by writing one;
    // a new event in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_q <= 2'b00;
        end else begin
            sts_q[epc_pkg::STS_ABORT] <= abort |
                (sts_q[epc_pkg::STS_ABORT] & ~(wr_sts & wd[epc_pkg::STS_ABORT]));
            sts_q[epc_pkg::STS_DONE] <= cyc_done |
                (sts_q[epc_pkg::STS_DONE] & ~(wr_sts & wd[epc_pkg::STS_DONE]));
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_o             <= 1'b0;
            latch_o          <= 1'b0;
            erase_o          <= 1'b0;
            erase_size_o     <= 2'b00;
            lat_addr_o       <= 11'h000;
            lat_data_o       <= 16'h0000;
            lat_word_o       <= 1'b0;
            shadow_sel_o     <= 1'b0;
            debug_lockout_o  <= 1'b1;
            clock_stop_o     <= 1'b0;
            array_wr_block_o <= 1'b0;
        end else begin
            hv_o             <= hv;
            latch_o          <= latch;
            erase_o          <= erase_m;
            erase_size_o     <= prog_q[4:3];
            lat_addr_o       <= lat_addr_q;
            lat_data_o       <= lat_data_q;
            lat_word_o       <= lat_word_q;
            shadow_sel_o     <= shadow_tgt;
            debug_lockout_o  <= ~cfg_q[epc_pkg::CFG_NODBG];
            clock_stop_o     <= stop_mode_i |
                                (wait_mode_i & cfg_q[epc_pkg::CFG_WAIT]);
            array_wr_block_o <= hv;
        end
    end
    assign ack_o = ack_q;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i | load_q);

    property p_div_latch;
        wr_dl & latch |=> $stable(div_lo_q);
    endproperty
    a_div_latch: assert property (p_div_latch) else $error("div changed");

    property p_zero_div;
        div_z |=> ~$rose(hv);
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("hv with zero div");

    property p_hv_latch;
        $rose(hv) |-> $past(latch) & captured_q;
    endproperty
    a_hv_latch: assert property (p_hv_latch) else $error("hv without latch");

    property p_freeze;
        hv & $past(hv) |-> $stable(prog_q[7:1]) & $stable(lat_addr_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen bits moved");

    property p_lock;
        plock & ~hv |=> $stable(prot_q);
    endproperty
    a_lock: assert property (p_lock) else $error("protect moved");

    property p_auto;
        cyc_done & prog_q[epc_pkg::PRG_AUTO] |=> ~hv ##1 ~hv_o;
    endproperty
    a_auto: assert property (p_auto) else $error("no self terminate");

    // stop, or wait with the clock-stop bit, must kill the cycle at once
    property p_abort;
        hv & (stop_mode_i | (wait_mode_i & cfg_q[epc_pkg::CFG_WAIT]))
            |=> ~hv & sts_q[epc_pkg::STS_ABORT];
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed");

    property p_test_rd;
        req & ~we_i & (idx == epc_pkg::IDX_TEST) & ~special_q
            |=> ack_o & (dat_o == 32'h0000_0000);
    endproperty
    a_test_rd: assert property (p_test_rd) else $error("test not zero");
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    // ************************************************************
    // bench signals, every design input driven from time zero
    // ************************************************************
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic [9:0]  adr_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic        we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
    logic [3:0]  sel_i = '0;
    logic        special_mode_low_i = 1'b1, oscillator_input_i = 1'b0;
    logic        wait_mode_i = 1'b0, stop_mode_i = 1'b0;
    logic [15:0] shadow_word_i = '0, arr_data_i = '0, lat_data_o;
    logic        arr_wr_i = 1'b0, arr_word_i = 1'b0;
    logic [10:0] arr_addr_i = '0, lat_addr_o, a;
    logic        hv_o, latch_o, erase_o, lat_word_o, shadow_sel_o;
    logic        debug_lockout_o, clock_stop_o, array_wr_block_o;
    logic [1:0]  erase_size_o, osc_cnt = '0;
    logic [7:0]  rd;
    logic [15:0] sh, d;
    logic [10:0] blk_lo [6] = '{11'h7C0, 11'h780, 11'h700,
                                11'h600, 11'h400, 11'h000};
    int          blk_sz [6] = '{64, 64, 128, 256, 512, 1024};
    int          err_count = 0, cmp_count = 0, k, t_up;

    epc_top epc_top_inst (.*);

    // bus clock; oscillator at a quarter rate, well below clk/2
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        osc_cnt <= osc_cnt + 2'h1;
        oscillator_input_i <= osc_cnt[1];
    end

    // ************************************************************
    // tasks and expectation helpers
    // ************************************************************
    function automatic int hv_cycles(input int dv);
        return ((10_000_000 + 34_999) / 35_000) * dv * 4;
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    // classic cycle: hold everything until ack is sampled high
    // no ack limit here: only the watchdog ends a hung cycle
    task automatic wb(input logic w, input logic [7:0] idx, wd);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hF};
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, wd};
        do @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic rdc(input logic [7:0] idx, exp, input string m);
        wb(1'b0, idx, 8'h00);
        chk(rd, exp, m);
    endtask
    task automatic arwr(input logic [10:0] ad, input logic [15:0] dt);
        @(posedge clk_i);
        {arr_wr_i, arr_addr_i, arr_data_i, arr_word_i} <= {1'b1, ad, dt, 1'b1};
        @(posedge clk_i);
        arr_wr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // latch, capture, request high voltage, then close in two writes
    task automatic try_hv(input logic [10:0] ad, input logic [7:0] pv,
                          input logic exp);
        wb(1'b1, epc_pkg::IDX_PROG, pv | 8'h02);
        arwr(ad, 16'($urandom));
        wb(1'b1, epc_pkg::IDX_PROG, pv | 8'h03);
        repeat (2) @(posedge clk_i);
        chk(hv_o, exp, "hv grant");
        wb(1'b1, epc_pkg::IDX_PROG, pv | 8'h02);
        wb(1'b1, epc_pkg::IDX_PROG, pv & 8'hFC);
    endtask
    task automatic do_reset(input logic sm, input logic [15:0] s);
        @(posedge clk_i);
        {rst_i, special_mode_low_i, shadow_word_i} <= {1'b1, sm, s};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(47804));
        sh = 16'($urandom) & 16'hFC00;
        do_reset(1'b1, sh);
        rdc(epc_pkg::IDX_CONFIG, {sh[15:12], 4'hC}, "cfg");
        rdc(epc_pkg::IDX_PROTECT, 8'hFF, "prot rst");
        rdc(epc_pkg::IDX_PROG, 8'h80, "prog rst");
        rdc(epc_pkg::IDX_DIV_LO, 8'h00, "div lo");
        chk(debug_lockout_o, 1'(~sh[15]), "lockout");
        wb(1'b1, epc_pkg::IDX_TEST, 8'hFF);
        rdc(epc_pkg::IDX_TEST, 8'h00, "test normal");
        rdc(8'h10, 8'h00, "unmapped");
        wb(1'b1, epc_pkg::IDX_PROG, 8'h82);
        rdc(epc_pkg::IDX_PROG, 8'h80, "latch zero div");
        wb(1'b1, epc_pkg::IDX_DIV_HI, 8'h00);
        wb(1'b1, epc_pkg::IDX_DIV_LO, 8'h03);
        wb(1'b1, epc_pkg::IDX_DIV_LO, 8'h09);
        rdc(epc_pkg::IDX_DIV_LO, 8'h03, "div once");
        $display("test reset and divider done");
        // timed cycle with self termination
        a = 11'($urandom % 1984) & 11'h7FE;
        d = 16'($urandom);
        wb(1'b1, epc_pkg::IDX_PROTECT, 8'h00);
        wb(1'b1, epc_pkg::IDX_PROG, 8'h22);
        arwr(a | 11'h1, ~d);
        chk(lat_word_o, 0, "misaligned");
        arwr(a, d);
        chk({lat_addr_o, lat_data_o, lat_word_o, latch_o},
            {a, d, 1'b1, 1'b1}, "latched");
        wb(1'b1, epc_pkg::IDX_PROG, 8'h23);
        repeat (2) @(posedge clk_i);
        t_up = $time - 30;
        chk(hv_o, 1, "hv set");
        arwr(a ^ 11'h2, ~d);
        chk({lat_addr_o, array_wr_block_o}, {a, 1'b1}, "frozen");
        wb(1'b1, epc_pkg::IDX_PROG, 8'h3D);
        rdc(epc_pkg::IDX_PROG, 8'h23, "ctl frozen");
        k = 0;
        while (hv_o === 1'b1 && k < 8000) begin
            @(posedge clk_i);
            k++;
        end
        k = ($time - t_up) / 10 - hv_cycles(3);
        chk(k > -24 && k < 24, 1, "cycle length");
        rdc(epc_pkg::IDX_STATUS, 8'h02, "done");
        wb(1'b1, epc_pkg::IDX_STATUS, 8'h03);
        rdc(epc_pkg::IDX_PROG, 8'h22, "auto clear");
        $display("test auto cycle done");
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, epc_pkg::IDX_PROTECT, 8'(1 << i));
            try_hv(blk_lo[i] + 11'(blk_sz[i] - 2), 8'h00, 1'b0);
            try_hv(blk_lo[i] - 11'h2, 8'h00, 1'b1);
        end
        wb(1'b1, epc_pkg::IDX_PROTECT, 8'h00);
        for (int s = 0; s < 4; s++) begin
            try_hv(a, 8'h84 | 8'(s << 3), s > 1);
            chk({erase_o, erase_size_o}, {1'b1, 2'(s)}, "esize");
        end
        try_hv(a, 8'h04, 1'b1);
        $display("test protection and erase done");
        wb(1'b1, epc_pkg::IDX_CONFIG, 8'h06);
        wb(1'b1, epc_pkg::IDX_PROTECT, 8'hFF);
        rdc(epc_pkg::IDX_PROTECT, 8'h40, "prot lock");
        wb(1'b1, epc_pkg::IDX_PROG, 8'h82);
        arwr(a, d);
        wb(1'b1, epc_pkg::IDX_PROG, 8'h03);
        repeat (40) @(posedge clk_i);
        chk(hv_o, 1, "manual hold");
        wait_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({clock_stop_o, hv_o}, 2'b10, "wait abort");
        rdc(epc_pkg::IDX_STATUS, 8'h01, "abort");
        wb(1'b1, epc_pkg::IDX_CONFIG, 8'h00);
        rdc(epc_pkg::IDX_CONFIG, {sh[15:12], 4'hA}, "lock once");
        repeat (2) @(posedge clk_i);
        chk(clock_stop_o, 0, "wait run");
        {wait_mode_i, stop_mode_i} <= 2'b01;
        repeat (3) @(posedge clk_i);
        chk(clock_stop_o, 1, "stop");
        stop_mode_i <= 1'b0;
        $display("test lock and abort done");
        sh = {4'($urandom), 12'h303};
        do_reset(1'b0, sh);
        rdc(epc_pkg::IDX_DIV_HI, 8'h03, "div hi");
        wb(1'b1, epc_pkg::IDX_DIV_LO, 8'h05);
        wb(1'b1, epc_pkg::IDX_DIV_LO, 8'h04);
        rdc(epc_pkg::IDX_DIV_LO, 8'h04, "div special");
        wb(1'b1, epc_pkg::IDX_TEST, 8'h5A);
        rdc(epc_pkg::IDX_TEST, 8'h5A, "test special");
        wb(1'b1, epc_pkg::IDX_CONFIG, 8'h80);
        repeat (2) @(posedge clk_i);
        chk(debug_lockout_o, 0, "lockout off");
        wb(1'b1, epc_pkg::IDX_CONFIG, 8'h00);
        wb(1'b1, epc_pkg::IDX_PROG, 8'h02);
        arwr(11'h7C0, d);
        chk(shadow_sel_o, 1, "shadow sel");
        wb(1'b1, epc_pkg::IDX_DIV_LO, 8'h07);
        rdc(epc_pkg::IDX_DIV_LO, 8'h04, "div latched");
        wb(1'b1, epc_pkg::IDX_PROG, 8'h00);
        wb(1'b1, epc_pkg::IDX_PROTECT, 8'h81);
        try_hv(11'h7C0, 8'h00, 1'b0);
        wb(1'b1, epc_pkg::IDX_PROTECT, 8'h01);
        try_hv(11'h7C0, 8'h00, 1'b1);
        $display("test special mode done");
        finish_test();
    end

    // watchdog well beyond the expected run of about 4000 cycles
    initial begin
        #400000;
        chk(0, 1, "watchdog");
        finish_test();
    end
endmodule
